// File: verilog/rxsc_top.sv
// Robot external start control: start handshake, inhibit functions, APB registers
//
// Design decisions made here: the APB slave port and the register addresses.
`include "rxsc_defines.svh"

// Behaviour
// - Start accepted only while ready; needs safety input on and no active start, stop-start or interlock inhibition.
// - Start valid when waiting at home, after temporary stop, or on wait job.
// - Accepted start from home wait also commands a move to home coordinates.
// - Start pulses of 20 ms or less are discarded as noise.
// - Ready is raised when a start-acceptable wait state begins, and not again after a start until that wait state ends.
// - Ready drops once an asserted start is accepted.
// - Assignable input defaults to free, with no system function.
// - Polarity type A acts on input on, type B on input off.
// - Start inhibition blocks starts only while robot is stopped.
// - Stop-start inhibition blocks when stopped; when moving, finish move then hold.
// - Software interlock blocks starts when stopped, urgent stop when moving.
// - Urgent-stop function stops urgently whenever active in run mode.
// - An input reads asserted exactly when its photocoupler conducts.
// - Halted output high while stationary, low while moving.
// - Ready always implies halted; halted may stand alone.
module rxsc_top
  import rxsc_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = `RXSC_CYC_PER_MS,
  parameter int unsigned FILTER_MS  = `RXSC_FILTER_MS
)
(
  input  wire logic                    clk_sys_in,
  input  wire logic                    reset_n_in,
  input  wire logic                    ce_in,
  input  wire logic                    psel_in,
  input  wire logic                    penable_in,
  input  wire logic                    pwrite_in,
  input  wire logic [`RXSC_ADDR_W-1:0] paddr_in,
  input  wire logic [31:0]             pwdata_in,
  output logic      [31:0]             prdata_out,
  output logic                         pready_out,
  output logic                         pslverr_out,
  input  wire logic                    ext_start_in,
  input  wire logic                    assignable_inhibit_in,
  input  wire logic                    safety_ok_in,
  input  wire logic                    ext_run_mode_in,
  input  wire logic                    robot_moving_in,
  input  wire logic                    wait_home_in,
  input  wire logic                    wait_temp_stop_in,
  input  wire logic                    wait_for_start_job_in,
  output logic                         ready_to_start_out,
  output logic                         robot_halted_out,
  output logic                         start_cmd_out,
  output logic                         home_move_out,
  output logic                         hold_req_out,
  output logic                         urgent_stop_out
);

  // ****************************************************************
  // Functions
  // ****************************************************************
  // Unknown codes fall back to free so a bad write cannot arm a stop
  function automatic rxsc_func_t rxsc_func_decode(input logic [2:0] v);
    rxsc_func_t f;
    case (v)
      3'h1:    f = RXSC_FN_START_INH;
      3'h2:    f = RXSC_FN_STOP_INH;
      3'h3:    f = RXSC_FN_SW_LOCK;
      3'h4:    f = RXSC_FN_URGENT;
      default: f = RXSC_FN_FREE;
    endcase
    return f;
  endfunction

  // ****************************************************************
  // Input filter
  // ****************************************************************
  rxsc_in_if u_in_if ();

  assign u_in_if.ce = ce_in;

  rxsc_in_filter
  #(
    .CYC_PER_MS (CYC_PER_MS),
    .FILTER_MS  (FILTER_MS)
  )
  u_filter
  (
    .clk_sys_in            (clk_sys_in),
    .reset_n_in            (reset_n_in),
    .ext_start_in          (ext_start_in),
    .assignable_inhibit_in (assignable_inhibit_in),
    .safety_ok_in          (safety_ok_in),
    .bus                   (u_in_if.filt)
  );

  // ****************************************************************
  // State
  // ****************************************************************
  rxsc_func_t   func_reg;
  logic         pol_b_reg;
  rxsc_state_t  state_reg;
  rxsc_state_t  state_next;
  logic         start_d_reg;
  logic         hold_reg;
  logic         hold_next;
  // Reset image of the control word, so its fields can be sliced
  localparam logic [31:0] CTRL_RST = `RXSC_CTRL_RESET;

  // ****************************************************************
  // Inhibit function decode
  // ****************************************************************
  wire logic stopped_w   = !robot_moving_in;
  wire logic inh_raw_w   = pol_b_reg ? !u_in_if.inhibit_lvl : u_in_if.inhibit_lvl;
  wire logic inh_act_w   = (func_reg != RXSC_FN_FREE) && inh_raw_w;
  wire logic fn_block_w  = (func_reg == RXSC_FN_START_INH) ||
                           (func_reg == RXSC_FN_STOP_INH)  ||
                           (func_reg == RXSC_FN_SW_LOCK);
  // Blocks only at standstill; a moving robot ignores start inhibition
  wire logic block_w     = fn_block_w && inh_act_w && stopped_w;
  wire logic hold_cond_w = (func_reg == RXSC_FN_STOP_INH) && inh_act_w
                           && robot_moving_in;
  wire logic urgent_w    = ((func_reg == RXSC_FN_SW_LOCK) && inh_act_w && robot_moving_in) ||
                           ((func_reg == RXSC_FN_URGENT) && inh_act_w
                            && ext_run_mode_in);

  // Hold lasts until the inhibit is released, then a fresh start resumes
  assign hold_next = hold_cond_w ||
                     (hold_reg && inh_act_w && (func_reg == RXSC_FN_STOP_INH));

  // ****************************************************************
  // Start handshake
  // ****************************************************************
  wire logic waiting_w = ext_run_mode_in && stopped_w &&
                         (wait_home_in || wait_temp_stop_in || wait_for_start_job_in);
  // Edge of the qualified start, so a held start cannot fire twice
  wire logic start_rise_w = u_in_if.start_q && !start_d_reg;
  wire logic accept_w     = (state_reg == RXSC_ST_READY) && start_rise_w
                            && u_in_if.safety_lvl && !block_w;

  // Next state of the handshake
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      RXSC_ST_IDLE:
        if (waiting_w)
          state_next = RXSC_ST_READY;
      RXSC_ST_READY:
        if (accept_w)
          state_next = RXSC_ST_TAKEN;
        else if (!waiting_w)
          state_next = RXSC_ST_IDLE;
      RXSC_ST_TAKEN:
        if (!waiting_w)
          state_next = RXSC_ST_IDLE;
      default:
        state_next = RXSC_ST_IDLE;
    endcase
  end

  // Handshake registers; ready and halted come from the same sample
  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in)
    begin
      state_reg          <= RXSC_ST_IDLE;
      start_d_reg        <= 1'b0;
      ready_to_start_out <= 1'b0;
      robot_halted_out   <= 1'b0;
      start_cmd_out      <= 1'b0;
      home_move_out      <= 1'b0;
      hold_reg           <= 1'b0;
      hold_req_out       <= 1'b0;
      urgent_stop_out    <= 1'b0;
    end
    else if (ce_in)
    begin
      state_reg          <= state_next;
      start_d_reg        <= u_in_if.start_q;
      ready_to_start_out <= (state_next == RXSC_ST_READY);
      robot_halted_out   <= stopped_w;
      start_cmd_out      <= accept_w;
      home_move_out      <= accept_w && wait_home_in;
      hold_reg           <= hold_next;
      hold_req_out       <= hold_next;
      urgent_stop_out    <= urgent_w;
    end
  end

  // ****************************************************************
  // APB slave
  // ****************************************************************
  wire logic        apb_setup_w = psel_in && !penable_in;
  wire logic        apb_acc_w   = psel_in && penable_in && pready_out;
  wire logic        hit_ctrl_w  = (paddr_in == `RXSC_ADDR_CTRL);
  wire logic        hit_stat_w  = (paddr_in == `RXSC_ADDR_STATUS);
  wire logic [31:0] ctrl_rd_w   = {28'h0, pol_b_reg, func_reg};
  wire logic [31:0] stat_rd_w   = {24'h0, state_reg, urgent_stop_out, hold_reg, block_w,
                                   inh_act_w, robot_halted_out, ready_to_start_out};
  wire logic [31:0] rd_mux_w    = hit_ctrl_w ? ctrl_rd_w :
                                  hit_stat_w ? stat_rd_w : 32'h0;

  // One wait-free access: answer raised in the cycle after setup
  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in)
    begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0;
    end
    else if (ce_in)
    begin
      pready_out  <= apb_setup_w;
      pslverr_out <= apb_setup_w && !(hit_ctrl_w || hit_stat_w);
      if (apb_setup_w)
        prdata_out <= pwrite_in ? 32'h0 : rd_mux_w;
    end
  end

  // Control register; status writes are ignored
  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in)
    begin
      func_reg  <= rxsc_func_decode(CTRL_RST[`RXSC_CTRL_FUNC_MSB:`RXSC_CTRL_FUNC_LSB]);
      pol_b_reg <= CTRL_RST[`RXSC_CTRL_POL_BIT];
    end
    else if (ce_in && apb_acc_w && pwrite_in && hit_ctrl_w)
    begin
      func_reg <= rxsc_func_decode(pwdata_in[`RXSC_CTRL_FUNC_MSB:`RXSC_CTRL_FUNC_LSB]);
      pol_b_reg <= pwdata_in[`RXSC_CTRL_POL_BIT];
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_ready_halted;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    ready_to_start_out |-> robot_halted_out;
  endproperty
  a_ready_halted: assert property (p_ready_halted)
    else $error("ready shown while robot not halted");

  property p_halted_track;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    ce_in |=> (robot_halted_out == !$past(robot_moving_in));
  endproperty
  a_halted_track: assert property (p_halted_track)
    else $error("halted output does not follow motion");

  property p_start_needs_ready;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    $rose(start_cmd_out) |-> $past(ready_to_start_out) && !ready_to_start_out;
  endproperty
  a_start_needs_ready: assert property (p_start_needs_ready)
    else $error("start accepted without ready or ready kept high");

  property p_ready_drops;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    (ce_in && accept_w) |=> !ready_to_start_out ##1 (!ce_in || !ready_to_start_out);
  endproperty
  a_ready_drops: assert property (p_ready_drops)
    else $error("ready did not drop after accepted start");

  property p_block_start;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    (ce_in && block_w) |=> !start_cmd_out;
  endproperty
  a_block_start: assert property (p_block_start)
    else $error("start issued while inhibited at standstill");

  property p_hold;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    (ce_in && hold_cond_w) |=> hold_req_out;
  endproperty
  a_hold: assert property (p_hold)
    else $error("hold not requested for stop-start inhibit in motion");

  property p_urgent;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    (ce_in && inh_act_w && func_reg == RXSC_FN_URGENT && ext_run_mode_in) |=> urgent_stop_out;
  endproperty
  a_urgent: assert property (p_urgent)
    else $error("urgent stop missing for active urgent input");

  property p_home_with_start;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    home_move_out |-> start_cmd_out;
  endproperty
  a_home_with_start: assert property (p_home_with_start)
    else $error("home move without accepted start");

  property p_func_legal;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    func_reg inside {RXSC_FN_FREE, RXSC_FN_START_INH, RXSC_FN_STOP_INH,
                     RXSC_FN_SW_LOCK, RXSC_FN_URGENT};
  endproperty
  a_func_legal: assert property (p_func_legal)
    else $error("illegal function selected");

  c_start: cover property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    $rose(start_cmd_out));
  c_hold: cover property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    $rose(hold_req_out));
  c_urgent: cover property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    $rose(urgent_stop_out));
  c_ctrl_write: cover property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    apb_acc_w && pwrite_in && hit_ctrl_w);

endmodule

// File: verilog/rxsc_defines.svh
// Constants of the robot external start control block: timing, offsets, fields, resets
`ifndef RXSC_DEFINES_SVH
`define RXSC_DEFINES_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define RXSC_CLK_MHZ          250
`define RXSC_CYC_PER_MS       (`RXSC_CLK_MHZ * 1000)
`define RXSC_FILTER_MS        20
`define RXSC_MIN_START_MS     30

// ****************************************************************
// Register map (byte addresses, 32-bit words)
// ****************************************************************
`define RXSC_ADDR_W           12
`define RXSC_ADDR_CTRL        12'h000
`define RXSC_ADDR_STATUS      12'h004

// ****************************************************************
// Control word fields and reset value
// ****************************************************************
`define RXSC_CTRL_FUNC_LSB    0
`define RXSC_CTRL_FUNC_MSB    2
`define RXSC_CTRL_POL_BIT     3
`define RXSC_CTRL_RESET       32'h0000_0000

// ****************************************************************
// Status word fields
// ****************************************************************
`define RXSC_ST_READY_BIT     0
`define RXSC_ST_HALTED_BIT    1
`define RXSC_ST_INH_BIT       2
`define RXSC_ST_BLOCK_BIT     3
`define RXSC_ST_HOLD_BIT      4
`define RXSC_ST_URGENT_BIT    5
`define RXSC_ST_STATE_LSB     6
`define RXSC_ST_STATE_MSB     7

`endif

// File: verilog/rxsc_pkg.sv
// Types of the robot external start control block
package rxsc_pkg;

  // Function of the assignable inhibit input
  typedef enum logic [2:0]
  {
    RXSC_FN_FREE      = 3'h0,
    RXSC_FN_START_INH = 3'h1,
    RXSC_FN_STOP_INH  = 3'h2,
    RXSC_FN_SW_LOCK   = 3'h3,
    RXSC_FN_URGENT    = 3'h4
  } rxsc_func_t;

  // Start handshake states, Gray along idle, ready, taken
  typedef enum logic [1:0]
  {
    RXSC_ST_IDLE  = 2'h0,
    RXSC_ST_READY = 2'h1,
    RXSC_ST_TAKEN = 2'h3
  } rxsc_state_t;

endpackage

// File: verilog/rxsc_in_if.sv
// Carrier between the input filter and the start control core
interface rxsc_in_if;
  logic ce;
  logic start_q;
  logic inhibit_lvl;
  logic safety_lvl;

  modport filt
  (
    input  ce,
    output start_q,
    output inhibit_lvl,
    output safety_lvl
  );

  modport core
  (
    output ce,
    input  start_q,
    input  inhibit_lvl,
    input  safety_lvl
  );
endinterface

// File: verilog/rxsc_in_filter.sv
// Pin synchronisers, millisecond timebase and start pulse width qualifier
`include "rxsc_defines.svh"

module rxsc_in_filter
  import rxsc_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = `RXSC_CYC_PER_MS,
  parameter int unsigned FILTER_MS  = `RXSC_FILTER_MS
)
(
  input  wire logic  clk_sys_in,
  input  wire logic  reset_n_in,
  input  wire logic  ext_start_in,
  input  wire logic  assignable_inhibit_in,
  input  wire logic  safety_ok_in,
  rxsc_in_if.filt    bus
);

  localparam int unsigned N          = 3;
  localparam int unsigned DIV_W      = $clog2(CYC_PER_MS + 1);
  localparam int unsigned QUAL_TICKS = FILTER_MS + 1;
  localparam int unsigned MS_W       = $clog2(QUAL_TICKS + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CYC_PER_MS - 1);
  localparam logic [MS_W-1:0]  MS_SAT   = MS_W'(QUAL_TICKS);
  localparam int unsigned FILTER_CYC = FILTER_MS * CYC_PER_MS;

  // Photocoupler conducting reads as one, whatever the wiring polarity
  wire logic [N-1:0] pin_w = {safety_ok_in, assignable_inhibit_in, ext_start_in};

  logic [N-1:0]      s1_reg;
  logic [N-1:0]      s2_reg;
  logic [N-1:0]      s3_reg;
  logic [N-1:0]      lvl_reg;
  logic [DIV_W-1:0]  div_reg;
  logic              tick_reg;
  logic [MS_W-1:0]   ms_reg;
  logic [31:0]       hi_cyc_reg;

  // ****************************************************************
  // Synchronisers
  // ****************************************************************
  // Three stages; level moves only when stages two and three agree
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_sync
      always_ff @(posedge clk_sys_in)
      begin
        if (!reset_n_in)
        begin
          s1_reg[g]  <= 1'b0;
          s2_reg[g]  <= 1'b0;
          s3_reg[g]  <= 1'b0;
          lvl_reg[g] <= 1'b0;
        end
        else if (bus.ce)
        begin
          s1_reg[g] <= pin_w[g];
          s2_reg[g] <= s1_reg[g];
          s3_reg[g] <= s2_reg[g];
          if (s2_reg[g] == s3_reg[g])
            lvl_reg[g] <= s3_reg[g];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Millisecond timebase and width qualifier
  // ****************************************************************
  // Free running divider; tick phase jitter costs at most one ms of delay
  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in)
    begin
      div_reg  <= '0;
      tick_reg <= 1'b0;
    end
    else if (bus.ce)
    begin
      div_reg  <= (div_reg == DIV_LAST) ? '0 : div_reg + 1'b1;
      tick_reg <= (div_reg == DIV_LAST);
    end
  end

  // Count ms ticks while start is high; short pulses never reach saturation
  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in)
      ms_reg <= '0;
    else if (bus.ce)
    begin
      if (!lvl_reg[0])
        ms_reg <= '0;
      else if (tick_reg && ms_reg != MS_SAT)
        ms_reg <= ms_reg + 1'b1;
    end
  end

  assign bus.start_q     = lvl_reg[0] && (ms_reg == MS_SAT);
  assign bus.inhibit_lvl = lvl_reg[1];
  assign bus.safety_lvl  = lvl_reg[2];

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Helper: cycles the filtered start level has stood high
  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in || !lvl_reg[0])
      hi_cyc_reg <= '0;
    else if (bus.ce && hi_cyc_reg != 32'hffff_ffff)
      hi_cyc_reg <= hi_cyc_reg + 32'h1;
  end

  property p_no_short_start;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    $rose(bus.start_q) |-> (hi_cyc_reg >= FILTER_CYC);
  endproperty
  a_no_short_start: assert property (p_no_short_start)
    else $error("start qualified after too short a pulse");

  property p_sync_delay;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    (bus.ce && s2_reg[1] == s3_reg[1]) |=> (lvl_reg[1] == $past(s3_reg[1]));
  endproperty
  a_sync_delay: assert property (p_sync_delay)
    else $error("inhibit level did not follow agreeing stages");

endmodule

// File: tb/rxsc_plc_model.sv
// External controller model driving the isolated start, inhibit and safety pins
module rxsc_plc_model
(
  input  wire logic clk_sys_in,
  input  wire logic ready_to_start_in,
  output logic      ext_start_out,
  output logic      inhibit_out,
  output logic      safety_ok_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Pins idle off, safety terminal closed
  initial
  begin
    ext_start_out = 1'b0;
    inhibit_out   = 1'b0;
    safety_ok_out = 1'b1;
  end

  // Press start n cycles; with ack keep it until ready drops, bounded
  task automatic press(input int n, input bit ack);
    int k;
    ext_start_out <= 1'b1;
    repeat (n) @(posedge clk_sys_in);
    k = 0;
    while (ack && ready_to_start_in === 1'b1 && k < 100)
    begin
      @(posedge clk_sys_in);
      k++;
    end
    ext_start_out <= 1'b0;
    @(posedge clk_sys_in);
  endtask

  // Inhibit level; released before any restart after a hold
  task automatic set_inh(input logic v);
    inhibit_out <= v;
    @(posedge clk_sys_in);
  endtask
endmodule

// File: tb/robot_external_start_control_test.sv
// Self-checking bench of the robot external start control block
`include "rxsc_defines.svh"
module robot_external_start_control_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk, rst_n, psel, pen, pwr, pready, perr, wh, wt, wj, run, mov, ce;
  logic        st, inh, saf, rdy, halt, scmd, home, hold, urg, er;
  logic [11:0] paddr;
  logic [31:0] pwd, prd, rd, seed;
  int          err_total, checks_done, n_start, n_home, e_start, e_home, c;

  rxsc_top #(.CYC_PER_MS(10), .FILTER_MS(20)) dut
  (
    .clk_sys_in(clk), .reset_n_in(rst_n), .ce_in(ce), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwd),
    .prdata_out(prd), .pready_out(pready), .pslverr_out(perr),
    .ext_start_in(st), .assignable_inhibit_in(inh), .safety_ok_in(saf),
    .ext_run_mode_in(run), .robot_moving_in(mov), .wait_home_in(wh),
    .wait_temp_stop_in(wt), .wait_for_start_job_in(wj),
    .ready_to_start_out(rdy), .robot_halted_out(halt), .start_cmd_out(scmd),
    .home_move_out(home), .hold_req_out(hold), .urgent_stop_out(urg)
  );

  rxsc_plc_model plc
  (
    .clk_sys_in(clk), .ready_to_start_in(rdy), .ext_start_out(st),
    .inhibit_out(inh), .safety_ok_out(saf)
  );

  // Clock, 4 ns period
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Count command pulses as they appear
  always @(posedge clk)
  begin
    if (scmd === 1'b1) n_start++;
    if (home === 1'b1) n_home++;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1; pwr <= w; paddr <= a; pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    // A slave that never answers ends the run
    if (pready !== 1'b1)
    begin
      err_total++;
      end_sim();
    end
    rd = prd;
    er = perr;
    psel <= 1'b0; pen <= 1'b0;
    @(posedge clk);
  endtask

  // Behavioural expectation of ready and halted
  task automatic chk_lvl();
    chk("ready", rdy, run & !mov & (wh | wt | wj));
    chk("halted", halt, !mov);
  endtask

  initial
  begin
    seed = 32'h2493deb8;
    ce = 1'b1;
    {rst_n, psel, pen, pwr, wh, wt, wj, run, mov} = '0;
    paddr = '0;
    pwd = '0;
    {err_total, checks_done, n_start, n_home, e_start, e_home} = '0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk);
    chk_lvl();
    apb(1'b0, `RXSC_ADDR_CTRL, '0);
    chk("ctrl rst", rd, `RXSC_CTRL_RESET);
    apb(1'b0, 12'h008, '0);
    chk("unmapped", {rd[30:0], er}, 32'h1);
    // Every function code, random upper data
    for (c = 0; c < 8; c++)
    begin
      apb(1'b1, `RXSC_ADDR_CTRL, (xs() & 32'hfffffff0) | c);
      apb(1'b0, `RXSC_ADDR_CTRL, '0);
      chk("func", rd[2:0], (c > 4) ? 0 : c);
    end
    apb(1'b1, `RXSC_ADDR_CTRL, 32'h0);
    run <= 1'b1;
    // Each waiting state accepts one start
    for (c = 0; c < 3; c++)
    begin
      {wh, wt, wj} <= 3'b100 >> c;
      repeat (4) @(posedge clk);
      chk_lvl();
      chk("rdy_halt", rdy & !halt, 0);
      apb(1'b0, `RXSC_ADDR_STATUS, '0);
      chk("status", rd, 32'h43);
      // Controller keeps start at least 30 ms
      plc.press(300 + xs() % 100, 1'b1);
      repeat (3) @(posedge clk);
      e_start++;
      e_home += (c == 0);
      chk("starts", n_start, e_start);
      chk("homes", n_home, e_home);
      chk("ready drop", rdy, 0);
      {wh, wt, wj} <= 3'b000;
      repeat (4) @(posedge clk);
    end
    // Short pulse as noise, then safety off
    wh <= 1'b1;
    repeat (4) @(posedge clk);
    // Clock enable low freezes every output
    ce <= 1'b0;
    mov <= 1'b1;
    repeat (5) @(posedge clk);
    chk("frozen", {rdy, halt}, 2'b11);
    ce <= 1'b1;
    mov <= 1'b0;
    repeat (2) @(posedge clk);
    // Exactly 20 ms is still noise
    plc.press(200, 1'b0);
    repeat (20) @(posedge clk);
    chk("noise", n_start, e_start);
    plc.safety_ok_out <= 1'b0;
    plc.press(300, 1'b0);
    chk("safety", n_start, e_start);
    plc.safety_ok_out <= 1'b1;
    // Inhibit functions, both polarities, stopped then moving
    for (c = 2; c < 10; c++)
    begin
      apb(1'b1, `RXSC_ADDR_CTRL, ((c % 2) << 3) | (c / 2));
      plc.set_inh(~c[0]);
      repeat (10) @(posedge clk);
      if (c < 8) plc.press(300, 1'b0);
      chk("blocked", n_start, e_start);
      mov <= 1'b1;
      repeat (10) @(posedge clk);
      chk_lvl();
      chk("hold", hold, c / 2 == 2);
      chk("urgent", urg, c / 2 >= 3);
      apb(1'b0, `RXSC_ADDR_STATUS, '0);
      chk("st moving", rd, 32'h4 | ((c / 2 == 2) ? 32'h10 : 32'h0) |
          ((c / 2 >= 3) ? 32'h20 : 32'h0));
      plc.set_inh(c[0]);
      mov <= 1'b0;
      repeat (10) @(posedge clk);
      chk("released", {hold, urg}, 0);
    end
    // Restart once the inhibit is off
    apb(1'b1, `RXSC_ADDR_CTRL, 32'h2);
    plc.set_inh(1'b0);
    repeat (10) @(posedge clk);
    plc.press(300, 1'b1);
    repeat (3) @(posedge clk);
    e_start++;
    chk("restart", n_start, e_start);
    end_sim();
  end

  // Watchdog against a hang
  initial
  begin
    repeat (100000) @(posedge clk);
    err_total++;
    end_sim();
  end
endmodule
